// ---- include/ffds_map.svh ----
// Constants for the flyback fault and dither sequencer: codes, counts and reference steps.
// Assumes one 25 MHz clock; all analog levels arrive as comparator flags.
// Notes on behaviour
// RULE1: End each on-time when sensed current reaches the peak limit, every cycle.
// RULE2: First over-current level on three consecutive cycles starts fault shutdown and retry.
// RULE3: Second over-current level stops switching at once, no qualification.
// RULE4: Supply clamp over-current is a fault that stops operation.
// RULE5: Over-temperature stops switching and drops to fault supply current.
// RULE6: Restart while still hot gives no switching and keeps the fault state.
// RULE7: Every thermal shutdown sends one short diagnostic pulse on the peak-set pin.
// RULE8: Dither repeats every twelve cycles as three groups of four.
// RULE9: Groups are centre/nominal, low frequency/high peak, high frequency/low peak.
// RULE10: In constant-current mode dither modulates only the peak setting.
// RULE11: Dither is off while the controller is in its light-load wait state.
// RULE12: Startup source runs reduced below one volt supply, higher current above.
// RULE13: Above turn-on threshold switching starts in voltage or current mode by load.
// RULE14: Voltage mode holds voltage below max current; current mode holds current.
// RULE15: Below turn-off threshold stop switching, source off, start supply current.
// RULE16: After a fault, fault current until turn-off threshold, then start current.
// RULE17: After stop, source on below recharge threshold until turn-on threshold.
// RULE18: A persistent fault cycles endlessly through stop, discharge, recharge, restart.
// RULE19: Never turn the switch on without a sensed zero-crossing event.
// RULE20: First three cycles after each start use one third of maximum peak.
// RULE21: Input under-voltage is a fault only after three consecutive cycles.
// RULE22: Consecutive-cycle counters sample once per cycle, clear on a clean cycle.
// RULE23: Dither group counter resets whenever switching restarts after a stop.
`ifndef FFDS_MAP_SVH
`define FFDS_MAP_SVH
`define FFDS_QUAL_CYCLES 2'h3
`define FFDS_SOFT_CYCLES 2'h3
`define FFDS_GROUP_LEN 2'h3
`define FFDS_GROUP_LAST 2'h2
`define FFDS_DIAG_NS 2000
`define FFDS_CLK_NS 40
`define FFDS_DIAG_CYC ((`FFDS_DIAG_NS + `FFDS_CLK_NS - 1) / `FFDS_CLK_NS)
`define FFDS_PK_FULL 8'hFF
`define FFDS_PK_THIRD 8'h55
`define FFDS_PK_STEP 8'h09
`define FFDS_FDEV_NONE 2'h0
`define FFDS_FDEV_DOWN 2'h1
`define FFDS_FDEV_UP 2'h2
`endif

// ---- include/ffds_pkg.sv ----
// Types shared by the sequencer and its dither stepper.
// Assumes ffds_map.svh constants are in scope of users.
package ffds_pkg;
  typedef enum logic [1:0] {FFDS_CENTRE, FFDS_LOW_F, FFDS_HIGH_F} ffds_group_e;
  typedef struct packed {
    logic [7:0] peak_ref;
    logic [1:0] freq_dev;
  } ffds_dither_s;
  typedef struct packed {
    logic ocp1;
    logic ocp2;
    logic clamp;
    logic hot;
    logic uvlo_in;
    logic ovp;
  } ffds_fault_s;
endpackage : ffds_pkg

// ---- logic/ffds_dither.sv ----
// Dither stepper: twelve-cycle pattern of three four-cycle groups.
// Assumes cycle_end pulses once per completed switching cycle.
`timescale 1ns/100ps
`include "ffds_map.svh"
module ffds_dither
(
  input wire logic clock,
  input wire logic rst,
  input wire logic restart,
  input wire logic cycle_end,
  input wire logic enable,
  input wire logic cc_mode,
  input wire logic [7:0] base_peak,
  output ffds_pkg::ffds_dither_s dout
);
  logic [1:0] in_group;
  ffds_pkg::ffds_group_e group;
  logic [7:0] peak_hi;
  logic [7:0] peak_lo;

  // Group advance every four cycles; restart returns to centre group
  always_ff @(posedge clock)
  begin
    if (rst || restart)
    begin
      in_group <= 2'h0; // [RULE23]
      group <= ffds_pkg::FFDS_CENTRE;
    end
    else if (cycle_end)
    begin
      in_group <= in_group + 2'h1;
      if (in_group == `FFDS_GROUP_LEN) // [RULE8]
        unique case (group)
          ffds_pkg::FFDS_CENTRE: group <= ffds_pkg::FFDS_LOW_F;
          ffds_pkg::FFDS_LOW_F: group <= ffds_pkg::FFDS_HIGH_F;
          ffds_pkg::FFDS_HIGH_F: group <= ffds_pkg::FFDS_CENTRE;
          default: group <= ffds_pkg::FFDS_CENTRE;
        endcase
    end
  end

  // Saturating steps so a full-scale base cannot wrap
  assign peak_hi = (base_peak > (`FFDS_PK_FULL - `FFDS_PK_STEP)) ? `FFDS_PK_FULL :
                   base_peak + `FFDS_PK_STEP;
  assign peak_lo = (base_peak < `FFDS_PK_STEP) ? 8'h00 : base_peak - `FFDS_PK_STEP;

  // Registered outputs; frequency held at centre in current mode
  always_ff @(posedge clock)
  begin
    if (rst)
      dout <= '0;
    else if (!enable || group == ffds_pkg::FFDS_CENTRE) // [RULE11] [RULE9]
      dout <= {base_peak, `FFDS_FDEV_NONE};
    else if (group == ffds_pkg::FFDS_LOW_F)
      dout <= {peak_hi, cc_mode ? `FFDS_FDEV_NONE : `FFDS_FDEV_DOWN}; // [RULE10]
    else
      dout <= {peak_lo, cc_mode ? `FFDS_FDEV_NONE : `FFDS_FDEV_UP}; // [RULE10]
  end

  dither_period_a: assert property (@(posedge clock) disable iff (rst || restart)
    (cycle_end && in_group == 2'h3 && group == ffds_pkg::FFDS_HIGH_F)
    |=> group == ffds_pkg::FFDS_CENTRE) else $error("dither did not wrap"); // [RULE8]
  dither_wait_a: assert property (@(posedge clock) disable iff (rst)
    !enable |=> dout.freq_dev == `FFDS_FDEV_NONE && dout.peak_ref == $past(base_peak))
    else $error("dither active in wait"); // [RULE11]
  dither_cc_a: assert property (@(posedge clock) disable iff (rst)
    cc_mode |=> dout.freq_dev == `FFDS_FDEV_NONE) else $error("freq dither in cc"); // [RULE10]
  dither_restart_a: assert property (@(posedge clock) disable iff (rst)
    restart |=> group == ffds_pkg::FFDS_CENTRE && in_group == 2'h0)
    else $error("restart kept group"); // [RULE23]
endmodule : ffds_dither

// ---- logic/ffds_sequencer.sv ----
// Flyback fault and dither sequencer: supply sequencing, fault qualifying, gate request.
// Assumes all comparator flags are asynchronous to clock and are synchronised here.
`timescale 1ns/100ps
`include "ffds_map.svh"
module ffds_sequencer
(
  input wire logic clock,
  input wire logic rst,
  input wire logic supply_above_1v,
  input wire logic supply_above_on,
  input wire logic supply_below_off,
  input wire logic supply_below_recharge,
  input wire logic peak_reached,
  input wire logic ocp1_level,
  input wire logic ocp2_level,
  input wire logic clamp_over,
  input wire logic over_temp,
  input wire logic input_uv,
  input wire logic output_ov,
  input wire logic zero_crossing_event,
  input wire logic period_elapsed,
  input wire logic cc_request,
  input wire logic light_wait,
  input wire logic [7:0] law_peak,
  output logic gate_on,
  output logic [7:0] peak_ref,
  output logic [1:0] freq_dev,
  output logic startup_src_on,
  output logic startup_src_high,
  output logic fault_current,
  output logic constant_current_mode,
  output logic diag_pulse
);
  typedef enum logic [2:0] {ST_CHARGE, ST_RUN, ST_FAULT, ST_IDLE} ffds_state_e;
  localparam int DIAG_CYC = `FFDS_DIAG_CYC;
  localparam int NIN = 14;

  // Two-flop synchronisers on every analog flag
  logic [NIN-1:0] raw;
  logic [NIN-1:0] meta;
  logic [NIN-1:0] sync;
  assign raw = {supply_above_1v, supply_above_on, supply_below_off, supply_below_recharge,
                peak_reached, ocp1_level, ocp2_level, clamp_over, over_temp, input_uv,
                output_ov, zero_crossing_event, period_elapsed, light_wait};
  always_ff @(posedge clock)
  begin
    meta <= raw;
    sync <= meta;
  end
  wire s_above_1v = sync[13];
  wire s_above_on = sync[12];
  wire s_below_off = sync[11];
  wire s_below_rech = sync[10];
  wire s_peak = sync[9];
  wire s_ocp1 = sync[8];
  wire s_ocp2 = sync[7];
  wire s_clamp = sync[6];
  wire s_hot = sync[5];
  wire s_uv = sync[4];
  wire s_ov = sync[3];
  wire s_zcd = sync[2];
  wire s_period = sync[1];
  wire s_wait = sync[0];

  ffds_state_e state;
  ffds_state_e next_state;
  logic zcd_seen;
  logic ocp1_hit;
  logic uv_hit;
  logic [1:0] ocp1_cnt;
  logic [1:0] uv_cnt;
  logic [1:0] soft_cnt;
  logic [7:0] diag_cnt;
  logic restart;
  logic cycle_end;
  logic fault_now;
  logic thermal_trip;
  logic soft_phase;
  logic [7:0] base_peak;
  ffds_pkg::ffds_dither_s dith;
  ffds_pkg::ffds_fault_s flt;

  // Cycle ends when the on-time is cut by the peak comparator
  assign cycle_end = gate_on && s_peak; // [RULE1]
  assign flt.ocp1 = cycle_end && (ocp1_hit || s_ocp1) && ocp1_cnt == 2'h2; // [RULE2]
  assign flt.ocp2 = s_ocp2; // [RULE3]
  assign flt.clamp = s_clamp; // [RULE4]
  assign flt.hot = s_hot; // [RULE5]
  assign flt.uvlo_in = cycle_end && (uv_hit || s_uv) && uv_cnt == 2'h2; // [RULE21]
  assign flt.ovp = s_ov;
  assign fault_now = (state == ST_RUN) && (|flt);
  assign thermal_trip = fault_now && flt.hot;
  assign restart = (state != ST_RUN) && (next_state == ST_RUN);
  assign soft_phase = soft_cnt != `FFDS_SOFT_CYCLES;

  // Supply-driven state transitions; faults fall back to the hiccup loop
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_CHARGE:
        if (s_above_on)
          next_state = s_hot ? ST_FAULT : ST_RUN; // [RULE13] [RULE6]
      ST_RUN:
        if (fault_now)
          next_state = ST_FAULT; // [RULE2] [RULE3] [RULE4] [RULE5]
        else if (s_below_off)
          next_state = ST_IDLE; // [RULE15]
      ST_FAULT:
        if (s_below_off)
          next_state = ST_IDLE; // [RULE16]
      ST_IDLE:
        if (s_below_rech)
          next_state = ST_CHARGE; // [RULE17] [RULE18]
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state <= ST_CHARGE;
    else
      state <= next_state;
  end

  // Per-cycle latches; clearing on cycle end keeps the count honest per cycle
  always_ff @(posedge clock)
  begin
    if (rst || state != ST_RUN || cycle_end)
    begin
      ocp1_hit <= 1'b0;
      uv_hit <= 1'b0;
    end
    else
    begin
      ocp1_hit <= ocp1_hit || (gate_on && s_ocp1);
      uv_hit <= uv_hit || (gate_on && s_uv);
    end
  end

  // Consecutive-cycle counters, sampled once per cycle
  always_ff @(posedge clock)
  begin
    if (rst || state != ST_RUN)
    begin
      ocp1_cnt <= 2'h0;
      uv_cnt <= 2'h0;
    end
    else if (cycle_end)
    begin
      ocp1_cnt <= (ocp1_hit || s_ocp1) ? ocp1_cnt + 2'h1 : 2'h0; // [RULE22]
      uv_cnt <= (uv_hit || s_uv) ? uv_cnt + 2'h1 : 2'h0; // [RULE22]
    end
  end

  // Soft start: first three cycles after each start at one third peak
  always_ff @(posedge clock)
  begin
    if (rst || restart)
      soft_cnt <= 2'h0; // [RULE20]
    else if (cycle_end && soft_phase)
      soft_cnt <= soft_cnt + 2'h1;
  end

  // Valley gate: a zero crossing must be seen since the last on-time
  always_ff @(posedge clock)
  begin
    if (rst || gate_on || state != ST_RUN)
      zcd_seen <= 1'b0;
    else if (s_zcd)
      zcd_seen <= 1'b1; // [RULE19]
  end

  // Gate request: on after period and zero crossing, off at peak or any fault
  always_ff @(posedge clock)
  begin
    if (rst || state != ST_RUN || fault_now || next_state != ST_RUN)
      gate_on <= 1'b0; // [RULE3] [RULE15]
    else if (gate_on && s_peak)
      gate_on <= 1'b0; // [RULE1]
    else if (!gate_on && zcd_seen && s_period)
      gate_on <= 1'b1; // [RULE19]
  end

  // Mode flag follows the loop's request, only meaningful while running
  always_ff @(posedge clock)
  begin
    if (rst || state != ST_RUN)
      constant_current_mode <= 1'b0;
    else
      constant_current_mode <= cc_request; // [RULE14]
  end

  assign base_peak = soft_phase ? `FFDS_PK_THIRD : law_peak; // [RULE20]

  ffds_dither u_dither
  (
    .clock(clock),
    .rst(rst),
    .restart(restart),
    .cycle_end(cycle_end),
    .enable(!s_wait && !soft_phase),
    .cc_mode(constant_current_mode),
    .base_peak(base_peak),
    .dout(dith)
  );

  // Thermal diagnostic pulse, fixed length, one per shutdown
  always_ff @(posedge clock)
  begin
    if (rst)
      diag_cnt <= 8'h00;
    else if (thermal_trip)
      diag_cnt <= 8'(DIAG_CYC); // [RULE7]
    else if (diag_cnt != 8'h00)
      diag_cnt <= diag_cnt - 8'h01;
  end

  // Registered supply-side, peak reference, dither and diagnostic outputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      startup_src_on <= 1'b1;
      startup_src_high <= 1'b0;
      fault_current <= 1'b0;
      peak_ref <= 8'h00;
      freq_dev <= 2'h0;
      diag_pulse <= 1'b0;
    end
    else
    begin
      startup_src_on <= next_state == ST_CHARGE; // [RULE17] [RULE15]
      startup_src_high <= next_state == ST_CHARGE && s_above_1v; // [RULE12]
      fault_current <= next_state == ST_FAULT; // [RULE16] [RULE5]
      peak_ref <= dith.peak_ref;
      freq_dev <= dith.freq_dev;
      diag_pulse <= diag_cnt != 8'h00 || thermal_trip; // [RULE7]
    end
  end

  sequence s_third_ocp;
    cycle_end && ocp1_cnt == 2'h2 && (ocp1_hit || s_ocp1) && state == ST_RUN;
  endsequence
  ocp_qualify_a: assert property (@(posedge clock) disable iff (rst)
    s_third_ocp |=> state == ST_FAULT && !gate_on) else $error("ocp1 not qualified"); // [RULE2]
  ocp_fast_a: assert property (@(posedge clock) disable iff (rst)
    (state == ST_RUN && s_ocp2) |=> !gate_on && state == ST_FAULT)
    else $error("ocp2 not immediate"); // [RULE3]
  clamp_stop_a: assert property (@(posedge clock) disable iff (rst)
    (state == ST_RUN && s_clamp) |=> state == ST_FAULT) else $error("clamp fault missed"); // [RULE4]
  hot_current_a: assert property (@(posedge clock) disable iff (rst)
    thermal_trip |=> fault_current && diag_pulse) else $error("thermal stop wrong"); // [RULE5]
  hot_restart_a: assert property (@(posedge clock) disable iff (rst)
    (state == ST_CHARGE && s_above_on && s_hot) |=> state == ST_FAULT && !gate_on)
    else $error("hot restart switched"); // [RULE6]
  diag_load_a: assert property (@(posedge clock) disable iff (rst)
    thermal_trip |=> diag_cnt == 8'(DIAG_CYC)) else $error("diag length not loaded"); // [RULE7]
  diag_len_a: assert property (@(posedge clock) disable iff (rst)
    $rose(diag_pulse) && !thermal_trip |-> ##1 diag_pulse) else $error("diag pulse short"); // [RULE7]
  zcd_gate_a: assert property (@(posedge clock) disable iff (rst)
    $rose(gate_on) |-> $past(zcd_seen)) else $error("turn-on without zcd"); // [RULE19]
  soft_peak_a: assert property (@(posedge clock) disable iff (rst)
    restart |=> ##2 peak_ref == `FFDS_PK_THIRD) else $error("soft start peak wrong"); // [RULE20]
  off_stop_a: assert property (@(posedge clock) disable iff (rst)
    (state == ST_RUN && s_below_off) |=> !gate_on && state != ST_RUN)
    else $error("no stop at turn-off"); // [RULE15]
  src_off_a: assert property (@(posedge clock) disable iff (rst)
    (state == ST_IDLE && !s_below_rech) |=> !startup_src_on) else $error("source on early"); // [RULE17]
  uv_qualify_a: assert property (@(posedge clock) disable iff (rst)
    (cycle_end && uv_cnt == 2'h2 && (uv_hit || s_uv) && state == ST_RUN) |=> state == ST_FAULT)
    else $error("uv not qualified"); // [RULE21]
endmodule : ffds_sequencer

// ---- test/ffds_sequencer_bench.sv ----
// Bench for the flyback sequencer: startup, soft start, dither, fault stop and retry.
// Assumes the sequencer alone; this bench drives every comparator flag itself.
`timescale 1ns/100ps
`include "ffds_map.svh"
module ffds_sequencer_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic supply_above_1v = 1'b0, supply_above_on = 1'b0, supply_below_off = 1'b0;
  logic supply_below_recharge = 1'b0, peak_reached = 1'b0, ocp1_level = 1'b0;
  logic ocp2_level = 1'b0, clamp_over = 1'b0, over_temp = 1'b0, input_uv = 1'b0;
  logic output_ov = 1'b0, zero_crossing_event = 1'b0, period_elapsed = 1'b0;
  logic cc_request = 1'b0, light_wait = 1'b0;
  logic [7:0] law_peak = 8'h40;
  logic gate_on, startup_src_on, startup_src_high, fault_current, constant_current_mode;
  logic diag_pulse;
  logic [7:0] peak_ref;
  logic [1:0] freq_dev;
  int n_fail = 0, tests_run = 0, n_cyc = 0, seed = 46, diag_cycles = 0;

  ffds_sequencer ffds_sequencer_inst (.clock, .rst, .supply_above_1v, .supply_above_on,
    .supply_below_off, .supply_below_recharge, .peak_reached, .ocp1_level, .ocp2_level,
    .clamp_over, .over_temp, .input_uv, .output_ov, .zero_crossing_event, .period_elapsed,
    .cc_request, .light_wait, .law_peak, .gate_on, .peak_ref, .freq_dev, .startup_src_on,
    .startup_src_high, .fault_current, .constant_current_mode, .diag_pulse);

  // Free-running clock
  always #(`FFDS_CLK_NS / 2) clock = ~clock;

  // Diagnostic pulse width, counted in sampled cycles
  always @(posedge clock)
    if (diag_pulse === 1'b1)
      diag_cycles <= diag_cycles + 1;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  function automatic logic sel(input int w);
    case (w)
      0: sel = gate_on;
      1: sel = fault_current;
      2: sel = startup_src_on;
      default: sel = startup_src_high;
    endcase
  endfunction : sel

  // Bounded wait; flags pass two synchroniser stages, so no exact count is assumed
  task automatic wait_for(input int w, input logic v, input string what);
    int i;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clock);
      #1;
      if (sel(w) === v)
        break;
    end
    chk(what, {7'h00, sel(w)}, {7'h00, v});
  endtask : wait_for

  task automatic stays(input int w, input logic v, input int n, input string what);
    int i;
    logic bad;
    bad = 1'b0;
    for (i = 0; i < n; i++)
    begin
      @(posedge clock);
      #1;
      if (sel(w) !== v)
        bad = 1'b1;
    end
    chk(what, {7'h00, bad}, 8'h00);
  endtask : stays

  // Peak and deviation expected at cycle n; soft start holds dither off
  function automatic logic [9:0] expect_cycle(input int n, input logic [7:0] law,
    input logic cc, input logic lw);
    int g;
    // Soft-start cycles count into the first centre group after each restart
    g = (n / 4) % 3;
    if (n < 3)
      return {`FFDS_PK_THIRD, `FFDS_FDEV_NONE};
    if (lw)
      return {law, `FFDS_FDEV_NONE};
    case (g)
      1: return {law + `FFDS_PK_STEP, cc ? `FFDS_FDEV_NONE : `FFDS_FDEV_DOWN};
      2: return {law - `FFDS_PK_STEP, cc ? `FFDS_FDEV_NONE : `FFDS_FDEV_UP};
      default: return {law, `FFDS_FDEV_NONE};
    endcase
  endfunction : expect_cycle

  task automatic zc_pulse();
    @(posedge clock);
    zero_crossing_event <= 1'b1;
    repeat (2) @(posedge clock);
    zero_crossing_event <= 1'b0;
  endtask : zc_pulse

  // One peak-terminated switching cycle, optional over-current or under-voltage
  task automatic sw_cycle(input logic o1, input logic uv);
    logic [9:0] e;
    @(posedge clock);
    // Taken after the edge so a mode change made just before the call is seen
    e = expect_cycle(n_cyc, law_peak, cc_request, light_wait);
    ocp1_level <= o1;
    input_uv <= uv;
    zc_pulse();
    wait_for(0, 1'b1, "gate rise");
    chk("peak_ref", peak_ref, e[9:2]);
    chk("freq_dev", {6'h00, freq_dev}, {6'h00, e[1:0]});
    chk("cc mode", {7'h00, constant_current_mode}, {7'h00, cc_request});
    @(posedge clock);
    peak_reached <= 1'b1;
    wait_for(0, 1'b0, "gate fall");
    @(posedge clock);
    peak_reached <= 1'b0;
    ocp1_level <= 1'b0;
    input_uv <= 1'b0;
    repeat (4) @(posedge clock);
    n_cyc++;
  endtask : sw_cycle

  // Stop, discharge, recharge and turn on again with a fresh random law peak
  task automatic restart();
    @(posedge clock);
    supply_above_on <= 1'b0;
    supply_below_off <= 1'b1;
    wait_for(1, 1'b0, "fault released");
    stays(2, 1'b0, 8, "source idle");
    @(posedge clock);
    supply_below_recharge <= 1'b1;
    wait_for(2, 1'b1, "source recharge");
    @(posedge clock);
    supply_below_off <= 1'b0;
    supply_below_recharge <= 1'b0;
    supply_above_on <= 1'b1;
    law_peak <= 8'($random(seed) & 32'h7F) + 8'h20;
    wait_for(2, 1'b0, "source off on");
    n_cyc = 0;
  endtask : restart

  // Immediate faults: 0 second over-current, 1 clamp, 2 output over-voltage, 3 hot
  task automatic trip(input int k);
    restart();
    repeat (4) sw_cycle(1'b0, 1'b0);
    zc_pulse();
    wait_for(0, 1'b1, "gate pre-fault");
    diag_cycles = 0;
    @(posedge clock);
    ocp2_level <= (k == 0);
    clamp_over <= (k == 1);
    output_ov <= (k == 2);
    over_temp <= (k == 3);
    wait_for(0, 1'b0, "gate stop");
    wait_for(1, 1'b1, "fault current");
    repeat (80) @(posedge clock);
    chk("diag len", 8'(diag_cycles), (k == 3) ? 8'(`FFDS_DIAG_CYC + 1) : 8'h00);
    @(posedge clock);
    ocp2_level <= 1'b0;
    clamp_over <= 1'b0;
    output_ov <= 1'b0;
    if (k == 3)
    begin
      restart();
      wait_for(1, 1'b1, "hot restart");
      zc_pulse();
      stays(0, 1'b0, 30, "hot no gate");
      @(posedge clock);
      over_temp <= 1'b0;
    end
    $display("test trip %0d done", k);
  endtask : trip

  task automatic final_report();
    $display("counts: %0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    int i;
    int u;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("gate reset", {7'h00, gate_on}, 8'h00);
    chk("source reset", {7'h00, startup_src_on}, 8'h01);
    stays(3, 1'b0, 6, "reduced source");
    @(posedge clock);
    supply_above_1v <= 1'b1;
    wait_for(3, 1'b1, "higher source");
    @(posedge clock);
    period_elapsed <= 1'b1;
    supply_above_on <= 1'b1;
    wait_for(2, 1'b0, "source off on");
    stays(0, 1'b0, 20, "no zero cross");
    $display("test startup done");
    repeat (27) sw_cycle(1'b0, 1'b0);
    @(posedge clock);
    cc_request <= 1'b1;
    repeat (12) sw_cycle(1'b0, 1'b0);
    @(posedge clock);
    cc_request <= 1'b0;
    light_wait <= 1'b1;
    repeat (4) sw_cycle(1'b0, 1'b0);
    @(posedge clock);
    light_wait <= 1'b0;
    $display("test dither done");
    // Cycle 2 is clean, so only cycles 3 to 5 form the qualifying run
    for (u = 0; u < 2; u++)
    begin
      restart();
      repeat (3) sw_cycle(1'b0, 1'b0);
      for (i = 0; i < 6; i++)
      begin
        sw_cycle(i != 2 && u == 0, i != 2 && u == 1);
        if (i < 5)
          chk("early fault", {7'h00, fault_current}, 8'h00);
      end
      wait_for(1, 1'b1, "qualified fault");
      zc_pulse();
      stays(0, 1'b0, 20, "fault no gate");
      $display("test qualify %0d done", u);
    end
    for (i = 0; i < 4; i++)
      trip(i);
    restart();
    sw_cycle(1'b0, 1'b0);
    final_report();
  end

  // Watchdog, far beyond the expected run length
  initial
  begin
    #(`FFDS_CLK_NS * 40000);
    n_fail++;
    final_report();
  end
endmodule : ffds_sequencer_bench
